// File: inc/plw_pkg.sv
/*
 * Shared constants and types for the port pin and low-power wake block:
 * register byte offsets, field positions, reset values and state codes.
 * Assumes a 32-bit APB slave port decoding the low eight address bits.
 */
package plw_pkg;

   localparam int unsigned   PORT_W = 6;
   localparam int unsigned   ADDR_W = 8;

   // register byte offsets
   localparam logic [7:0]    OFS_PORT_C_DATA  = 8'h00;
   localparam logic [7:0]    OFS_PORT_C_DIR   = 8'h04;
   localparam logic [7:0]    OFS_PORT_A_DATA  = 8'h08;
   localparam logic [7:0]    OFS_PORT_A_DIR   = 8'h0c;
   localparam logic [7:0]    OFS_PORT_A_CHG   = 8'h10;
   localparam logic [7:0]    OFS_ANALOG_SEL   = 8'h14;
   localparam logic [7:0]    OFS_CMP_CTRL     = 8'h18;
   localparam logic [7:0]    OFS_POWER_CTRL   = 8'h1c;
   localparam logic [7:0]    OFS_IRQ_CTRL     = 8'h20;
   localparam logic [7:0]    OFS_CORE_CTRL    = 8'h24;

   // field positions
   localparam int unsigned   POWER_WAKE_EN_BIT = 5;
   localparam int unsigned   IRQ_GLOBAL_BIT    = 7;
   localparam int unsigned   IRQ_CHANGE_EN_BIT = 3;
   localparam int unsigned   IRQ_CHANGE_FLAG_BIT = 0;
   localparam int unsigned   CORE_SLEEP_BIT    = 0;
   localparam int unsigned   CORE_VREF_EXT_BIT = 1;
   localparam int unsigned   CORE_ASLEEP_BIT   = 4;
   localparam int unsigned   CMP_MODE_LSB      = 0;

   // values after reset
   localparam logic [5:0]    RST_LATCH        = 6'h00;
   localparam logic [5:0]    RST_DIR          = 6'h3f;
   localparam logic [5:0]    RST_CHANGE_EN    = 6'h00;
   localparam logic [7:0]    RST_ANALOG_SEL   = 8'hff;
   localparam logic [2:0]    RST_CMP_MODE     = 3'h0;

   // comparator mode in which no comparator pin is forced analog; the analog select alone decides
   localparam logic [2:0]    CMP_MODE_OFF     = 3'h7;
   localparam logic [12:0]   ISR_VECTOR       = 13'h0004;

   typedef enum logic [2:0] {
      ST_RUN   = 3'b001,
      ST_SLEEP = 3'b010,
      ST_WAKE  = 3'b100
   } plw_state_t;

endpackage

// File: inc/plw_port_if.sv
/*
 * Bundle between the register side and one six-pin port slice.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface plw_port_if;
   logic [5:0] latch;
   logic [5:0] dir;
   logic [5:0] analog;
   logic [5:0] change_en;
   logic [5:0] rd;
   logic [5:0] change;

   modport ctl  (output latch, dir, analog, change_en, input rd, change);
   modport port (input latch, dir, analog, change_en, output rd, change);
endinterface

// File: rtl/plw_port.sv
/*
 * One six-pin bidirectional port: drivers, read path and change detect.
 * Assumes pin inputs are already synchronous to the clock.
 */
`timescale 1ns/1ps
module plw_port
   import plw_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   // register side
   plw_port_if.port         bus,
   // pins
   input  wire logic [5:0]  pin_i,
   output logic [5:0]       pin_o,
   output logic [5:0]       pin_oe_o
);

   logic [5:0] last;

   assign pin_o    = bus.latch;            // [RQ16]
   assign pin_oe_o = ~bus.dir;             // [RQ13]
   // analog pins read low whatever the pin level
   assign bus.rd   = pin_i & ~bus.analog;  // [RQ11] [RQ12]

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         last <= '0;
      end else begin
         last <= bus.rd;
      end
   end

   // any edge counts; a slow fall is seen once it reads low
   assign bus.change = (bus.rd ^ last) & bus.change_en;  // [RQ15] [RQ2]

endmodule

// File: rtl/plw_top.sv
/*
 * Port A and port C pin logic with the low-power wake path on port A
 * pin 0, reached over APB. Assumes a single clock, synchronous pins and
 * a core that treats sleep_o, wake_o and isr_call_o as its sleep hooks.
 */
`timescale 1ns/1ps
// Overview of operation
// RQ1: wake enable bit switches on pin0 current sink
// RQ2: slow fall on pin0 raises change event
// RQ3: software charges, enables detect, inputs, enables, sleeps
// RQ4: pin0 below low threshold wakes, resumes next
// RQ5: global enable set vectors to fixed address
// RQ6: pin0 functions: io, adc, comparator, program, wake
// RQ7: comparator mode and analog select choose analog
// RQ8: pin1 functions: io, adc, comparator, vref, clock
// RQ9: port C has six bidirectional pins
// RQ10: software sets analog select before digital use
// RQ11: analog pins read as zero
// RQ12: port C reads pin level high or low
// RQ13: direction one is input, zero output
// RQ14: port C direction bits 7:6 read zero
// RQ15: change enable bit enables change interrupt
// RQ16: data write loads latch driving output pins
module plw_top
   import plw_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        srst_i,
   // apb slave
   input  wire logic [7:0]  paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // port a pins
   input  wire logic [5:0]  port_a_pin_i,
   output logic [5:0]       port_a_pin_o,
   output logic [5:0]       port_a_pin_oe_o,
   // port c pins
   input  wire logic [5:0]  port_c_pin_i,
   output logic [5:0]       port_c_pin_o,
   output logic [5:0]       port_c_pin_oe_o,
   // analog routing
   output logic             low_power_wake_sink_o,
   output logic [5:0]       port_a_analog_o,
   output logic [5:0]       port_c_analog_o,
   output logic             adc_vref_ext_o,
   // serial programming
   input  wire logic        prog_mode_i,
   input  wire logic        prog_data_out_i,
   input  wire logic        prog_data_oe_i,
   output logic             serial_program_data_o,
   output logic             serial_program_clock_o,
   // core hooks
   output logic             sleep_o,
   output logic             wake_o,
   output logic             isr_call_o,
   output logic [12:0]      isr_addr_o
);

   plw_port_if pa_if ();
   plw_port_if pc_if ();

   logic [5:0]  port_a_latch;
   logic [5:0]  port_a_dir;
   logic [5:0]  port_c_latch;
   logic [5:0]  port_c_dir;
   logic [5:0]  port_a_change_enable;
   logic [7:0]  analog_select_reg;
   logic [2:0]  comparator_mode;
   logic        low_power_wake_enable;
   logic        global_irq_enable;
   logic        change_irq_enable;
   logic        change_flag;
   logic        vref_ext;
   logic [5:0]  pa_pin_o;
   logic [5:0]  pa_pin_oe;
   logic        wr_en;
   logic        rd_setup;
   logic        change_hit;
   logic        flag_clear;
   logic        sleep_cmd;
   logic        call_now;
   logic [31:0] next_rdata;
   logic        next_err;
   plw_state_t  state;
   plw_state_t  next_state;

   // pins that count as analog for a port
   function automatic logic [5:0] analog_mask(input logic       is_c,
                                              input logic [7:0] sel,
                                              input logic [2:0] mode);
      logic [5:0] m;
      m = '0;
      if (is_c) begin
         m[3:0] = sel[7:4];
      end else begin
         m[2:0] = sel[2:0];
         m[4]   = sel[3];
      end
      // comparator inputs sit on pins 1:0 of both ports
      if (mode != CMP_MODE_OFF) begin
         m[1:0] = 2'b11;
      end
      return m;
   endfunction

   // apb: zero wait states, read data captured in the setup cycle
   assign pready_o = 1'b1;
   assign wr_en    = psel_i & penable_i & pwrite_i;
   assign rd_setup = psel_i & ~penable_i;

   // routing into the port slices
   assign pa_if.latch     = port_a_latch;
   assign pa_if.dir       = port_a_dir;
   assign pa_if.analog    = analog_mask(1'b0, analog_select_reg, comparator_mode); // [RQ7]
   assign pa_if.change_en = port_a_change_enable;
   assign pc_if.latch     = port_c_latch;
   assign pc_if.dir       = port_c_dir;
   assign pc_if.analog    = analog_mask(1'b1, analog_select_reg, comparator_mode); // [RQ7] [RQ9]
   assign pc_if.change_en = '0;

   plw_port u_port_a (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .bus       (pa_if.port),
      .pin_i     (port_a_pin_i),
      .pin_o     (pa_pin_o),
      .pin_oe_o  (pa_pin_oe)
   );

   plw_port u_port_c (
      .ref_clk_i (ref_clk_i),
      .srst_i    (srst_i),
      .bus       (pc_if.port),
      .pin_i     (port_c_pin_i),
      .pin_o     (port_c_pin_o),
      .pin_oe_o  (port_c_pin_oe_o)                                 // [RQ9] [RQ13]
   );

   // programming mode takes pins 1:0; pin 1 is then clock input only
   always_comb begin
      port_a_pin_o    = pa_pin_o;
      port_a_pin_oe_o = pa_pin_oe;
      if (prog_mode_i) begin
         port_a_pin_o[0]    = prog_data_out_i;                     // [RQ6]
         port_a_pin_oe_o[0] = prog_data_oe_i;
         port_a_pin_o[1]    = 1'b0;                                // [RQ8]
         port_a_pin_oe_o[1] = 1'b0;
      end
   end

   // programming path bypasses the analog gate on purpose
   assign serial_program_data_o  = port_a_pin_i[0] & prog_mode_i;  // [RQ6]
   assign serial_program_clock_o = port_a_pin_i[1] & prog_mode_i;  // [RQ8]
   assign port_a_analog_o        = pa_if.analog;                   // [RQ6] [RQ8]
   assign port_c_analog_o        = pc_if.analog;
   // vref input only makes sense with pin 1 analog
   assign adc_vref_ext_o         = vref_ext & pa_if.analog[1];     // [RQ8]
   assign low_power_wake_sink_o  = low_power_wake_enable;          // [RQ1]

   // port data and direction registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         port_a_latch <= RST_LATCH;
         port_c_latch <= RST_LATCH;
      end else if (wr_en) begin
         if (paddr_i == OFS_PORT_A_DATA) begin
            port_a_latch <= pwdata_i[5:0];                          // [RQ16]
         end
         if (paddr_i == OFS_PORT_C_DATA) begin
            port_c_latch <= pwdata_i[5:0];                          // [RQ16]
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         port_a_dir <= RST_DIR;
         port_c_dir <= RST_DIR;
      end else if (wr_en) begin
         if (paddr_i == OFS_PORT_A_DIR) begin
            port_a_dir <= pwdata_i[5:0];
         end
         if (paddr_i == OFS_PORT_C_DIR) begin
            port_c_dir <= pwdata_i[5:0];                            // [RQ13]
         end
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         port_a_change_enable  <= RST_CHANGE_EN;
         analog_select_reg     <= RST_ANALOG_SEL;
         comparator_mode       <= RST_CMP_MODE;
         low_power_wake_enable <= 1'b0;
         vref_ext              <= 1'b0;
      end else if (wr_en) begin
         case (paddr_i)
            OFS_PORT_A_CHG: begin
               port_a_change_enable <= pwdata_i[5:0];               // [RQ15]
            end
            OFS_ANALOG_SEL: begin
               analog_select_reg <= pwdata_i[7:0];
            end
            OFS_CMP_CTRL: begin
               comparator_mode <= pwdata_i[CMP_MODE_LSB +: 3];
            end
            OFS_POWER_CTRL: begin
               low_power_wake_enable <= pwdata_i[POWER_WAKE_EN_BIT]; // [RQ1]
            end
            OFS_CORE_CTRL: begin
               vref_ext <= pwdata_i[CORE_VREF_EXT_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   // interrupt control; a change in the clearing cycle keeps the flag
   assign change_hit = |pa_if.change;                               // [RQ2]
   assign flag_clear = wr_en && (paddr_i == OFS_IRQ_CTRL)
                       && !pwdata_i[IRQ_CHANGE_FLAG_BIT];

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         global_irq_enable <= 1'b0;
         change_irq_enable <= 1'b0;
      end else if (wr_en && (paddr_i == OFS_IRQ_CTRL)) begin
         global_irq_enable <= pwdata_i[IRQ_GLOBAL_BIT];
         change_irq_enable <= pwdata_i[IRQ_CHANGE_EN_BIT];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         change_flag <= 1'b0;
      end else if (change_hit) begin
         change_flag <= 1'b1;                                       // [RQ2] [RQ15]
      end else if (flag_clear) begin
         change_flag <= 1'b0;
      end
   end

   // sleep and wake sequencing
   assign sleep_cmd = wr_en && (paddr_i == OFS_CORE_CTRL)
                      && pwdata_i[CORE_SLEEP_BIT];

   always_comb begin
      next_state = state;
      case (state)
         ST_RUN: begin
            if (sleep_cmd) begin
               next_state = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            // wake needs the change enable, not the global enable
            if (change_flag && change_irq_enable) begin
               next_state = ST_WAKE;                                // [RQ4]
            end
         end
         ST_WAKE: begin
            next_state = ST_RUN;
         end
         default: begin
            next_state = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         state <= ST_RUN;
      end else begin
         state <= next_state;
      end
   end

   assign sleep_o = (state == ST_SLEEP);
   assign wake_o  = (state == ST_WAKE);                             // [RQ4]

   // vector on wake, or on a new flag while running
   assign call_now = global_irq_enable && change_irq_enable
                     && ((state == ST_WAKE)
                         || ((state == ST_RUN) && change_hit && !change_flag));

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         isr_call_o <= 1'b0;
         isr_addr_o <= '0;
      end else begin
         isr_call_o <= call_now;                                    // [RQ5]
         if (call_now) begin
            isr_addr_o <= ISR_VECTOR;                               // [RQ5]
         end
      end
   end

   // read mux
   always_comb begin
      next_rdata = '0;
      next_err   = 1'b0;
      case (paddr_i)
         OFS_PORT_C_DATA: next_rdata[5:0] = pc_if.rd;               // [RQ11] [RQ12]
         OFS_PORT_C_DIR:  next_rdata[5:0] = port_c_dir;             // [RQ14]
         OFS_PORT_A_DATA: next_rdata[5:0] = pa_if.rd;               // [RQ11]
         OFS_PORT_A_DIR:  next_rdata[5:0] = port_a_dir;
         OFS_PORT_A_CHG:  next_rdata[5:0] = port_a_change_enable;
         OFS_ANALOG_SEL:  next_rdata[7:0] = analog_select_reg;
         OFS_CMP_CTRL:    next_rdata[CMP_MODE_LSB +: 3] = comparator_mode;
         OFS_POWER_CTRL:  next_rdata[POWER_WAKE_EN_BIT] = low_power_wake_enable;
         OFS_IRQ_CTRL: begin
            next_rdata[IRQ_GLOBAL_BIT]      = global_irq_enable;
            next_rdata[IRQ_CHANGE_EN_BIT]   = change_irq_enable;
            next_rdata[IRQ_CHANGE_FLAG_BIT] = change_flag;
         end
         OFS_CORE_CTRL: begin
            next_rdata[CORE_VREF_EXT_BIT] = vref_ext;
            next_rdata[CORE_ASLEEP_BIT]   = sleep_o;
         end
         default: next_err = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         prdata_o  <= '0;
         pslverr_o <= 1'b0;
      end else if (rd_setup) begin
         prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
         pslverr_o <= next_err;
      end
   end

endmodule

// File: tb/plw_checker.sv
/*
 * Assertions on the plw_top ports: port C register effects, read values,
 * wake sink and the sleep/wake/vector hooks.
 * Assumes one clock and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module plw_checker
   import plw_pkg::*;
(
   input wire logic        ref_clk_i,
   input wire logic        srst_i,
   input wire logic [7:0]  paddr_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic [5:0]  port_c_pin_o,
   input wire logic [5:0]  port_c_pin_oe_o,
   input wire logic [5:0]  port_c_analog_o,
   input wire logic        low_power_wake_sink_o,
   input wire logic        sleep_o,
   input wire logic        wake_o,
   input wire logic        isr_call_o,
   input wire logic [12:0] isr_addr_o
);
   wire wr = psel_i & penable_i & pwrite_i;
   wire rd = psel_i & penable_i & ~pwrite_i;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   a_dir_write: assert property (wr && paddr_i == OFS_PORT_C_DIR
      |=> port_c_pin_oe_o == ~$past(pwdata_i[5:0])) else $error("direction write lost");
   a_oe_hold: assert property ($changed(port_c_pin_oe_o)
      |-> $past(wr && paddr_i == OFS_PORT_C_DIR)) else $error("enable moved unprompted");
   a_data_write: assert property (wr && paddr_i == OFS_PORT_C_DATA
      |=> port_c_pin_o == $past(pwdata_i[5:0])) else $error("latch write lost");
   a_dir_read: assert property (rd && paddr_i == OFS_PORT_C_DIR
      |-> prdata_o == {26'h0, ~port_c_pin_oe_o}) else $error("direction read wrong");
   a_analog_zero: assert property (rd && paddr_i == OFS_PORT_C_DATA
      |-> (prdata_o[5:0] & port_c_analog_o) == 6'h0 && prdata_o[31:6] == 26'h0)
      else $error("analog pin read nonzero");
   a_sink_write: assert property (wr && paddr_i == OFS_POWER_CTRL
      |=> low_power_wake_sink_o == $past(pwdata_i[POWER_WAKE_EN_BIT]))
      else $error("sink enable wrong");
   a_sink_hold: assert property ($changed(low_power_wake_sink_o)
      |-> $past(wr && paddr_i == OFS_POWER_CTRL)) else $error("sink moved unprompted");
   a_wake_pulse: assert property ($rose(wake_o)
      |-> $past(sleep_o) ##1 (!wake_o && !sleep_o)) else $error("wake pulse wrong");
   a_isr_vector: assert property (isr_call_o
      |=> isr_addr_o == ISR_VECTOR) else $error("vector address wrong");
endmodule

bind plw_top plw_checker u_chk (.*);

// File: tb/plw_pin_model.sv
/*
 * Far side of the pins: external loads on every pin but port A pin 0, which has the RC.
 * Assumes the bench sets the undriven pin levels.
 */
`timescale 1ns/1ps
module plw_pin_model #(parameter int DISCHARGE = 40) (
   // from the device
   input wire logic       ref_clk_i,
   input wire logic [5:0] a_out_i,
   input wire logic [5:0] a_oe_i,
   input wire logic [5:0] c_out_i,
   input wire logic [5:0] c_oe_i,
   input wire logic       sink_i,
   // external loads
   input wire logic [5:0] a_ext_i,
   input wire logic [5:0] c_ext_i,
   // to the device
   output logic [5:0]     a_pin_o,
   output logic [5:0]     c_pin_o
);
   int cap = 0;
   // no leakage modelled: while undriven, the capacitor only drains through the sink
   always @(posedge ref_clk_i)
      if (a_oe_i[0]) cap <= a_out_i[0] ? DISCHARGE : 0;
      else if (sink_i && cap > 0) cap <= cap - 1;
   assign a_pin_o = {(a_oe_i[5:1] & a_out_i[5:1]) | (~a_oe_i[5:1] & a_ext_i[5:1]),
                     a_oe_i[0] ? a_out_i[0] : (cap > 0)};
   assign c_pin_o = (c_oe_i & c_out_i) | (~c_oe_i & c_ext_i);
endmodule

// File: tb/test_port_pins_low_power_wake.sv
/*
 * Self-checking bench for plw_top: APB master, pin partner, reference values.
 * Assumes plw_pkg offsets and zero-wait APB answers.
 */
`timescale 1ns/1ps
module test_port_pins_low_power_wake;
   import plw_pkg::*;
   logic        ref_clk_i = 0, srst_i = 1, psel = 0, pen = 0, pwr = 0, pready, perr, ev;
   logic [7:0]  paddr = 0;
   logic [31:0] pwdata = 0, prdata, rdv;
   logic [5:0]  a_o, a_oe, a_i, c_o, c_oe, c_i, a_an, c_an, e6, ext_c = 6'h3f;
   logic        sink, slp, wk, isr, vref, spd, spc, prog = 0, pdo = 0, pdoe = 0;
   logic [12:0] isr_a;
   int          fails = 0, n_checks = 0, dir_c, lat_c, m, sel, k;

   always #25 ref_clk_i = ~ref_clk_i;

   plw_top dut (.ref_clk_i, .srst_i, .paddr_i(paddr), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(perr), .port_a_pin_i(a_i), .port_a_pin_o(a_o), .port_a_pin_oe_o(a_oe),
      .port_c_pin_i(c_i), .port_c_pin_o(c_o), .port_c_pin_oe_o(c_oe),
      .low_power_wake_sink_o(sink), .port_a_analog_o(a_an), .port_c_analog_o(c_an),
      .adc_vref_ext_o(vref), .prog_mode_i(prog), .prog_data_out_i(pdo),
      .prog_data_oe_i(pdoe), .serial_program_data_o(spd), .serial_program_clock_o(spc),
      .sleep_o(slp), .wake_o(wk),
      .isr_call_o(isr), .isr_addr_o(isr_a));

   plw_pin_model #(.DISCHARGE(40)) u_pins (.ref_clk_i, .a_out_i(a_o), .a_oe_i(a_oe),
      .c_out_i(c_o), .c_oe_i(c_oe), .sink_i(sink), .a_ext_i(6'h3f), .c_ext_i(ext_c),
      .a_pin_o(a_i), .c_pin_o(c_i));

   task stop_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one transfer; results land in rdv/ev, outputs settled at the negedge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int j;
      @(posedge ref_clk_i);
      psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge ref_clk_i);
      pen <= 1;
      j = 0;
      do begin
         @(posedge ref_clk_i);
         j++;
      end while (pready !== 1'b1 && j < 20);
      rdv = prdata;
      ev = perr;
      psel <= 0; pen <= 0;
      if (j >= 20) begin
         fails++;
         stop_test;
      end
      @(negedge ref_clk_i);
   endtask

   initial begin
      void'($urandom(49324));
      repeat (3) @(posedge ref_clk_i);
      srst_i <= 0;
      apb(0, OFS_PORT_C_DIR, 0); chk("dir_reset", rdv, 32'h3f);
      apb(0, OFS_PORT_C_DATA, 0); chk("data_reset", rdv, 32'h30);
      apb(0, 8'hfc, 0); chk("unmapped_err", ev, 1);
      $display("test reset done");
      for (k = 0; k < 6; k++) begin
         m = k[0] ? 7 : $urandom_range(0, 6);
         sel = $urandom_range(0, 255);
         apb(1, OFS_CMP_CTRL, m); apb(1, OFS_ANALOG_SEL, sel);
         e6 = {2'b00, sel[7:6], sel[5:4] | {2{m != 7}}};
         chk("c_analog", c_an, e6);
         chk("a_analog", a_an[1:0], sel[1:0] | {2{m != 7}});
         @(posedge ref_clk_i) ext_c <= 6'($urandom);
         apb(0, OFS_PORT_C_DATA, 0);
         e6 = ext_c & ~e6;
         chk("c_read", rdv, e6);
      end
      $display("test analog done");
      apb(1, OFS_CMP_CTRL, 7); apb(1, OFS_ANALOG_SEL, 0);
      for (k = 0; k < 6; k++) begin
         lat_c = $urandom; dir_c = $urandom;
         apb(1, OFS_PORT_C_DATA, lat_c); apb(1, OFS_PORT_C_DIR, dir_c | 32'hc0);
         chk("c_out", c_o, lat_c[5:0]);
         e6 = ~dir_c[5:0];
         chk("c_oe", c_oe, e6);
         @(posedge ref_clk_i) ext_c <= 6'($urandom);
         apb(0, OFS_PORT_C_DIR, 0); chk("dir_read", rdv, dir_c[5:0]);
         apb(0, OFS_PORT_C_DATA, 0);
         e6 = (~dir_c[5:0] & lat_c[5:0]) | (dir_c[5:0] & ext_c);
         chk("c_pins", rdv, e6);
      end
      $display("test port c done");
      // pin 0 left undriven reads low while the capacitor is empty
      for (k = 0; k < 4; k++) begin
         @(posedge ref_clk_i);
         prog <= 1;
         pdo  <= k[0];
         pdoe <= k[1];
         @(negedge ref_clk_i);
         chk("prog_oe", a_oe[1:0], {1'b0, k[1]});
         chk("prog_pins", {a_o[0], spd, spc}, {k[0], k[0] & k[1], 1'b1});
      end
      @(posedge ref_clk_i);
      prog <= 0;
      @(negedge ref_clk_i);
      chk("prog_off", {spd, spc}, 2'b00);
      apb(1, OFS_CORE_CTRL, 2); chk("vref_digital", vref, 0);
      apb(1, OFS_ANALOG_SEL, 2); chk("vref_analog", vref, 1);
      apb(1, OFS_CORE_CTRL, 0); chk("vref_off", vref, 0);
      $display("test pin functions done");
      for (k = 1; k >= 0; k--) begin
         apb(1, OFS_POWER_CTRL, 0); apb(1, OFS_PORT_A_CHG, 0);
         apb(1, OFS_PORT_A_DATA, 1); apb(1, OFS_PORT_A_DIR, 32'h3e);
         chk("a_drive", {a_oe, a_o[0]}, {6'h01, 1'b1});
         apb(1, OFS_PORT_A_CHG, 1); apb(1, OFS_PORT_A_DIR, 32'h3f);
         apb(1, OFS_POWER_CTRL, 32'h20); chk("sink_on", sink, 1);
         apb(1, OFS_IRQ_CTRL, (k << 7) | 8); apb(1, OFS_CORE_CTRL, 1);
         chk("asleep", slp, 1);
         m = 0;
         while (wk !== 1'b1 && m < 400) begin
            @(negedge ref_clk_i);
            m++;
         end
         if (m >= 400) begin
            fails++;
            stop_test;
         end
         @(negedge ref_clk_i);
         chk("isr_call", isr, k);
         chk("awake", slp, 0);
         apb(0, OFS_IRQ_CTRL, 0); chk("flag_read", rdv, (k << 7) | 9);
      end
      chk("vector", isr_a, ISR_VECTOR);
      $display("test wake done");
      stop_test;
   end
endmodule
